// >>> hdl/tx_wave_pkg.sv
`default_nettype none

package tx_wave_pkg;

  // Fields of the RAM control register, bit 6 down to bit 0.
  typedef struct packed {
    logic       en;              // Enables RAM transfers.
    logic       dir;             // One reads the RAM, zero writes it.
    logic [4:0] template_index;  // Sample location as written.
  } wave_ctrl_s;

  // One pending sample RAM transfer.
  typedef struct packed {
    logic [4:0] ch;              // Channel number 0..21.
    logic       dir;             // One reads, zero writes.
    logic [4:0] index;           // Saturated sample location.
    logic [6:0] word;            // Sample to store on a write.
  } ram_req_s;

endpackage

`default_nettype wire

// >>> hdl/tx_waveform_template_regs.sv
// Contract
// [RQ1] Three registers per channel, 22 channels, mapped; the code maps four per channel
// [RQ2] Six-bit amplitude factor, upper bits reserved
// [RQ3] T1/J1 nominal 110110, two percent per step
// [RQ4] T1/J1 span plus twenty to minus hundred
// [RQ5] E1 nominal 100001, three percent per step
// [RQ6] E1 span plus hundred to minus hundred
// [RQ7] Factor resets T1 nominal; software sets E1
// [RQ8] RAM fields act only with arbitrary template
// [RQ9] Control bit 6 enables RAM access
// [RQ10] Control bit 5 selects read or write
// [RQ11] Index codes above eighteen address nineteen
// [RQ12] Seven-bit sample word, bit 7 reserved
// [RQ13] Sample word holds until rewritten
// [RQ14] Enabled read loads RAM sample into word
// [RQ15] Enabled write stores word into RAM
`timescale 1ns/1ps
`default_nettype none
`include "tx_waveform_template_regs.svh"

module tx_waveform_template_regs #(
  parameter int NUM_CH = 22  // Channels served.
) (
  input  wire logic                CLK_SYS_IN,      // System clock, 10 MHz.
  input  wire logic                SYS_RST_IN,      // Synchronous reset, active high.
  input  wire logic                PSEL_IN,         // APB select.
  input  wire logic                PENABLE_IN,      // APB access phase.
  input  wire logic                PWRITE_IN,       // APB direction, high writes.
  input  wire logic [12:0]         PADDR_IN,        // APB byte address.
  input  wire logic [31:0]         PWDATA_IN,       // APB write data.
  output logic      [31:0]         PRDATA_OUT,      // APB read data.
  output logic                     PREADY_OUT,      // APB ready.
  output logic                     PSLVERR_OUT,     // APB error, unmapped address.
  output logic      [NUM_CH*10-1:0] TX_AMPL_PCT_OUT, // Signed amplitude offset per channel.
  output logic      [NUM_CH-1:0]   E1_MODE_OUT,     // Channel uses an E1 template.
  output logic      [NUM_CH-1:0]   ARB_WAVE_EN_OUT  // Channel uses the arbitrary template.
);

  // Per-channel register storage.
  logic [5:0]              amp_ff  [NUM_CH];  // Amplitude factor.
  logic [3:0]              puls_ff [NUM_CH];  // Pulse template selection.
  tx_wave_pkg::wave_ctrl_s ctrl_ff [NUM_CH];  // RAM control fields.
  logic [6:0]              word_ff [NUM_CH];  // Template sample word.
  logic signed [9:0]       pct_ff  [NUM_CH];  // Amplitude offset in percent.

  // Bus handshake state.
  logic        rdy_ff;      // Access phase has its answer ready.
  logic        err_ff;      // Answer flags an unmapped address.
  logic [31:0] prdata_ff;   // Read data held for the answer.

  // Sample RAM transfer pipeline.
  logic                    pend_ff;  // Transfer issued to the RAM this cycle.
  tx_wave_pkg::ram_req_s   req_ff;   // The transfer being issued.
  logic                    rdv_ff;   // RAM read data is valid this cycle.
  logic [4:0]              ld_ch_ff; // Channel that receives the read data.
  logic [6:0]              ram_rdata; // Read data from the RAM.

  // Address decode.
  wire [10:0] reg_index  = PADDR_IN[12:2];        // Register index.
  wire [4:0]  blk        = reg_index[10:6];       // Channel block.
  wire [5:0]  low        = reg_index[5:0];        // Register within the block.
  wire        blk_low_ok = blk <= `LAST_LOW_BLOCK; // Channels 1..21.
  wire        blk_ch0    = blk == `CH0_BLOCK;     // Channel 0.
  wire [4:0]  sel_ch     = blk_ch0 ? 5'h00 : 5'(blk + 5'h01);   // see [RQ1]
  // Which of the registers inside the channel block is addressed.
  wire        hit_puls   = low == `PULSE_SEL_IDX;
  wire        hit_amp    = low == `AMP_FACTOR_IDX;
  wire        hit_ctrl   = low == `RAM_CTRL_IDX;
  wire        hit_data   = low == `RAM_DATA_IDX;
  // A misaligned or unknown address is answered with an error.
  wire        mapped     = (blk_low_ok || blk_ch0) && PADDR_IN[1:0] == 2'b00 &&
                           (hit_puls || hit_amp || hit_ctrl || hit_data);

  // Bus phases; the RAM pipeline stalls the access phase.
  wire busy     = pend_ff || rdv_ff;
  wire acc      = PSEL_IN && PENABLE_IN;
  wire acc_go   = acc && !busy && !rdy_ff;
  wire wr_ok    = acc && rdy_ff && PWRITE_IN && !err_ff;

  // Values as they stand after the write being taken.
  tx_wave_pkg::wave_ctrl_s new_ctrl;
  wire [6:0] new_word = (hit_data) ? PWDATA_IN[6:0] : word_ff[sel_ch];
  assign new_ctrl = hit_ctrl ? tx_wave_pkg::wave_ctrl_s'(PWDATA_IN[6:0]) : ctrl_ff[sel_ch];
  wire arb_sel   = puls_ff[sel_ch][3];                          // see [RQ8]
  wire trig      = wr_ok && (hit_ctrl || hit_data) && arb_sel && new_ctrl.en; // see [RQ9]
  wire [4:0] sat_idx = (new_ctrl.template_index > `LAST_SAMPLE) ?
                       `LAST_SAMPLE : new_ctrl.template_index;    // see [RQ11]

  // Read multiplexer; reserved bits read as zero.
  wire [31:0] rd_mux = !mapped  ? 32'h0000_0000 :
                       hit_puls ? {28'h000_0000, puls_ff[sel_ch]} :
                       hit_amp  ? {26'h000_0000, amp_ff[sel_ch]} :      // see [RQ2]
                       hit_ctrl ? {25'h000_0000, ctrl_ff[sel_ch]} :
                                  {25'h000_0000, word_ff[sel_ch]};      // see [RQ12]

  // Bus answer: ready one cycle after the access phase may proceed.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      rdy_ff    <= 1'b0;
      err_ff    <= 1'b0;
      prdata_ff <= 32'h0000_0000;
    end else begin
      // Ready is a one-cycle pulse; it cannot repeat while it stands.
      rdy_ff    <= acc_go;
      // The error flag travels with ready for unmapped addresses.
      err_ff    <= acc_go && !mapped;
      if (acc_go) begin
        prdata_ff <= rd_mux;
      end
    end
  end

  assign PREADY_OUT  = rdy_ff;
  assign PSLVERR_OUT = err_ff;
  assign PRDATA_OUT  = prdata_ff;

  // Register file: software writes, and RAM read-back into the sample word.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      // Every channel returns to its default register values.
      for (int c = 0; c < NUM_CH; c++) begin
        amp_ff[c]  <= `AMP_FACTOR_RST;                               // see [RQ3]
        puls_ff[c] <= `PULSE_SEL_RST;
        ctrl_ff[c] <= `RAM_CTRL_RST;
        word_ff[c] <= `RAM_DATA_RST;
      end
    end else begin
      // Template selection decides the mode and whether RAM fields act.
      if (wr_ok && hit_puls) begin
        puls_ff[sel_ch] <= PWDATA_IN[3:0];
      end
      // Only the six factor bits are kept; reserved bits are dropped.
      if (wr_ok && hit_amp) begin
        amp_ff[sel_ch] <= PWDATA_IN[5:0];                          // see [RQ2]
      end
      // Control fields are kept as written; the index saturates later.
      if (wr_ok && hit_ctrl) begin
        ctrl_ff[sel_ch] <= new_ctrl;                                // see [RQ10]
      end
      // A software write always updates the sample word.
      if (wr_ok && hit_data) begin
        word_ff[sel_ch] <= PWDATA_IN[6:0];                          // see [RQ13]
      end
      // Read-back lands while the bus is stalled, so no write meets it.
      if (rdv_ff) begin
        word_ff[ld_ch_ff] <= ram_rdata;                             // see [RQ14]
      end
    end
  end

  // Transfer pipeline: issue, then land read data one cycle later.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      pend_ff  <= 1'b0;
      req_ff   <= '0;
      rdv_ff   <= 1'b0;
      ld_ch_ff <= 5'h00;
    end else begin
      // A transfer is issued for exactly one cycle per trigger.
      pend_ff  <= trig;
      // The request holds until the next trigger replaces it.
      if (trig) begin
        req_ff <= '{ch: sel_ch, dir: new_ctrl.dir, index: sat_idx, word: new_word};
      end
      // Only reads return data, one cycle after the issue.
      rdv_ff   <= pend_ff && req_ff.dir;
      ld_ch_ff <= req_ff.ch;
    end
  end

  // The RAM holds 32 slots per channel; only 20 of each are used.
  wave_sample_ram #(
    .WIDTH (7),
    .DEPTH (NUM_CH * 32),
    .AW    (10)
  ) u_ram (
    .clk_in    (CLK_SYS_IN),
    .en_in     (pend_ff),
    .we_in     (!req_ff.dir),                                       // see [RQ15]
    .addr_in   ({req_ff.ch, req_ff.index}),
    .wdata_in  (req_ff.word),
    .rdata_out (ram_rdata)
  );

  // Amplitude offset in percent from the factor, mode and clamp.
  function automatic logic signed [9:0] scale_pct(input logic [5:0] code,
                                                  input logic e1);
    logic signed [9:0] delta;
    logic signed [9:0] raw;
    logic signed [9:0] top;
    // Distance of the code from the nominal code of the mode.
    delta = $signed({4'h0, code}) - (e1 ? `E1_NOMINAL : `T1_NOMINAL);  // see [RQ5]
    // Each step is worth a fixed percentage in each mode.
    raw   = 10'(delta * (e1 ? `E1_STEP_PCT : `T1_STEP_PCT));
    // The upper end of the span depends on the mode.
    top   = e1 ? `E1_MAX_PCT : `T1_MAX_PCT;                         // see [RQ6]
    if (raw > top) begin
      scale_pct = top;
    end else if (raw < `MIN_PCT) begin
      scale_pct = `MIN_PCT;
    end else begin
      scale_pct = raw;
    end
  endfunction

  // E1 templates are the two lowest selection codes; others scale as T1/J1.
  logic [NUM_CH-1:0] e1_w;   // E1 mode per channel.
  logic [NUM_CH-1:0] arb_w;  // Arbitrary template per channel.
  for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
    assign e1_w[g]  = puls_ff[g][3:1] == 3'b000;
    assign arb_w[g] = puls_ff[g][3];
    assign TX_AMPL_PCT_OUT[g*10 +: 10] = pct_ff[g];
  end
  assign E1_MODE_OUT     = e1_w;
  assign ARB_WAVE_EN_OUT = arb_w;

  // Register the per-channel amplitude offsets.
  always_ff @(posedge CLK_SYS_IN) begin
    if (SYS_RST_IN) begin
      for (int c = 0; c < NUM_CH; c++) begin
        pct_ff[c] <= 10'sh000;
      end
    end else begin
      for (int c = 0; c < NUM_CH; c++) begin
        pct_ff[c] <= scale_pct(amp_ff[c], e1_w[c]);                 // see [RQ4]
      end
    end
  end

  // Checks on the design's own behaviour.
  default clocking cb @(posedge CLK_SYS_IN); endclocking
  default disable iff (SYS_RST_IN);

  a_ch0_decode: assert property ( // see [RQ1]
    (acc && PADDR_IN == 13'h1F1C) |-> (mapped && sel_ch == 5'h00 && hit_amp))
    else $error("Channel 0 factor address not decoded.");

  a_amp_reserved: assert property ( // see [RQ2]
    (rdy_ff && !PWRITE_IN && hit_amp && mapped) |-> PRDATA_OUT[31:6] == 26'h000_0000)
    else $error("Reserved factor bits read non-zero.");

  a_t1_step: assert property ( // see [RQ3]
    (!e1_w[3] && amp_ff[3] == 6'h37 && $stable(amp_ff[3])) |=> pct_ff[3] == 10'sd2)
    else $error("T1 step above nominal is not two percent.");

  a_t1_span: assert property ( // see [RQ4]
    (!e1_w[3] && $stable(e1_w[3])) |=> (pct_ff[3] <= 10'sd20 && pct_ff[3] >= -10'sd100))
    else $error("T1 offset left its span.");

  a_e1_step: assert property ( // see [RQ5]
    (e1_w[0] && amp_ff[0] == 6'h22 && $stable(amp_ff[0]) && $stable(e1_w[0]))
      |=> pct_ff[0] == 10'sd3)
    else $error("E1 step above nominal is not three percent.");

  a_e1_span: assert property ( // see [RQ6]
    (e1_w[0] && $stable(e1_w[0])) |=> (pct_ff[0] <= 10'sd100 && pct_ff[0] >= -10'sd100))
    else $error("E1 offset left its span.");

  a_gate_template: assert property ( // see [RQ8]
    (wr_ok && (hit_ctrl || hit_data) && !arb_sel) |=> !pend_ff)
    else $error("RAM transfer without arbitrary template.");

  a_gate_enable: assert property ( // see [RQ9]
    (wr_ok && hit_ctrl && !PWDATA_IN[`CTRL_EN_BIT]) |=> !pend_ff)
    else $error("RAM transfer while access disabled.");

  a_dir_read: assert property ( // see [RQ10]
    (pend_ff && req_ff.dir) |=> rdv_ff ##1 !rdv_ff)
    else $error("Read transfer did not land its data.");

  a_index_sat: assert property ( // see [RQ11]
    (trig && new_ctrl.template_index >= 5'h13) |=> (pend_ff && req_ff.index == 5'h13))
    else $error("High index codes not saturated to nineteen.");

  a_word_hold: assert property ( // see [RQ13]
    !(wr_ok && hit_data && sel_ch == 5'h15) && !(rdv_ff && ld_ch_ff == 5'h15)
      |=> $stable(word_ff[21]))
    else $error("Sample word changed without a write.");

  a_read_load: assert property ( // see [RQ14]
    rdv_ff |=> word_ff[$past(ld_ch_ff)] == $past(ram_rdata))
    else $error("Read-back sample not loaded.");

  a_write_store: assert property ( // see [RQ15]
    (trig && !new_ctrl.dir) |=> (pend_ff && !req_ff.dir && req_ff.word == $past(new_word)))
    else $error("Write transfer carries the wrong sample.");

  a_busy_stall: assert property ( // see [RQ14]
    busy |=> !PREADY_OUT)
    else $error("Bus answered while the RAM was busy.");

  // Bus answer, register update and transfer checks.
  a_err_zero: assert property ( // see [RQ1]
    (rdy_ff && err_ff) |-> PRDATA_OUT == 32'h0000_0000)
    else $error("Refused access returned non-zero data.");

  a_err_answer: assert property ( // see [RQ1]
    (acc_go && !mapped) |=> PSLVERR_OUT)
    else $error("Unmapped address answered without error.");

  a_ready_pulse: assert property ( // see [RQ1]
    PREADY_OUT |=> !PREADY_OUT)
    else $error("Ready stood for more than one cycle.");

  a_idle_quiet: assert property ( // see [RQ1]
    !acc |=> !PREADY_OUT)
    else $error("Ready raised without an access phase.");

  a_amp_write: assert property ( // see [RQ2]
    (wr_ok && hit_amp) |=> amp_ff[$past(sel_ch)] == $past(PWDATA_IN[5:0]))
    else $error("Factor write did not land.");

  a_puls_write: assert property ( // see [RQ8]
    (wr_ok && hit_puls) |=> puls_ff[$past(sel_ch)] == $past(PWDATA_IN[3:0]))
    else $error("Template selection write did not land.");

  a_ctrl_write: assert property ( // see [RQ10]
    (wr_ok && hit_ctrl) |=> ctrl_ff[$past(sel_ch)] == $past(PWDATA_IN[6:0]))
    else $error("Control write did not land.");

  a_dir_write: assert property ( // see [RQ10]
    (pend_ff && !req_ff.dir) |=> !rdv_ff)
    else $error("Write transfer returned read data.");

  a_index_direct: assert property ( // see [RQ11]
    (trig && new_ctrl.template_index < 5'h13) |=>
      req_ff.index == $past(new_ctrl.template_index))
    else $error("Low index code not passed unchanged.");

  a_data_reserved: assert property ( // see [RQ12]
    (rdy_ff && !PWRITE_IN && hit_data && mapped) |-> PRDATA_OUT[31:7] == 25'h000_0000)
    else $error("Reserved sample bits read non-zero.");

  a_data_write: assert property ( // see [RQ13]
    (wr_ok && hit_data) |=> word_ff[$past(sel_ch)] == $past(PWDATA_IN[6:0]))
    else $error("Sample word write did not land.");

  // Main scenarios that the bench should reach.
  c_ram_write: cover property (pend_ff && !req_ff.dir);
  c_ram_read: cover property (rdv_ff ##1 (rdy_ff && !PWRITE_IN && hit_data));
  c_e1_nominal: cover property (e1_w[0] && amp_ff[0] == 6'h21);
  c_unmapped: cover property (rdy_ff && err_ff);
  c_index_high: cover property (trig && new_ctrl.template_index > `LAST_SAMPLE);

endmodule // tx_waveform_template_regs

`default_nettype wire

// >>> hdl/tx_waveform_template_regs.svh
`ifndef TX_WAVEFORM_TEMPLATE_REGS_SVH
`define TX_WAVEFORM_TEMPLATE_REGS_SVH

// Register indices within a channel block; byte address is four times the index.
`define PULSE_SEL_IDX   6'h06
`define AMP_FACTOR_IDX  6'h07
`define RAM_CTRL_IDX    6'h08
`define RAM_DATA_IDX    6'h09

// Channel block decode: blocks 0..20 hold channels 1..21, block 0x1F holds channel 0.
`define LAST_LOW_BLOCK  5'h14
`define CH0_BLOCK       5'h1F

// Field positions of the RAM control register.
`define CTRL_EN_BIT     6
`define CTRL_DIR_BIT    5

// Reset values.
`define AMP_FACTOR_RST  6'h36
`define PULSE_SEL_RST   4'h2
`define RAM_CTRL_RST    7'h00
`define RAM_DATA_RST    7'h00

// Amplitude scaling: nominal codes, percent per step and clamp limits of the span.
`define T1_NOMINAL      10'sh036
`define E1_NOMINAL      10'sh021
`define T1_STEP_PCT     10'sh002
`define E1_STEP_PCT     10'sh003
`define T1_MAX_PCT      10'sh014
`define E1_MAX_PCT      10'sh064
`define MIN_PCT         -10'sh064

// Highest sample location; larger index codes saturate to it.
`define LAST_SAMPLE     5'h13

`endif

// >>> hdl/wave_sample_ram.sv
`timescale 1ns/1ps
`default_nettype none

// Single-port sample memory with registered read data.
module wave_sample_ram #(
  parameter int WIDTH = 7,    // Bits per sample.
  parameter int DEPTH = 704,  // Number of locations.
  parameter int AW    = 10    // Address width.
) (
  input  wire logic             clk_in,    // System clock.
  input  wire logic             en_in,     // Access strobe.
  input  wire logic             we_in,     // Write when high, read when low.
  input  wire logic [AW-1:0]    addr_in,   // Location.
  input  wire logic [WIDTH-1:0] wdata_in,  // Sample to store.
  output logic      [WIDTH-1:0] rdata_out  // Sample read, one cycle later.
);

  logic [WIDTH-1:0] mem_ff [DEPTH];  // Sample storage, not reset.
  logic [WIDTH-1:0] rdata_ff;        // Read data register.

  // Store on a write, capture the location on a read.
  always_ff @(posedge clk_in) begin
    if (en_in && we_in) begin
      mem_ff[addr_in] <= wdata_in;
    end
    if (en_in && !we_in) begin
      rdata_ff <= mem_ff[addr_in];
    end
  end

  assign rdata_out = rdata_ff;

endmodule // wave_sample_ram

`default_nettype wire

// >>> testbench/tx_waveform_template_regs_tb.sv
`timescale 1ns/1ps
`default_nettype none

// Compares a design value with its expectation and counts both outcomes.
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin failures++; \
  $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module tx_waveform_template_regs_tb;
  logic          clk_sys;          // System clock, 100 ns period.
  logic          sys_rst;          // Synchronous reset, active high.
  logic          psel;             // APB select.
  logic          penable;          // APB access phase.
  logic          pwrite;           // APB direction.
  logic [12:0]   paddr;            // APB byte address.
  logic [31:0]   pwdata;           // APB write data.
  logic [31:0]   prdata;           // APB read data.
  logic          pready;           // APB ready.
  logic          pslverr;          // APB error.
  logic [219:0]  ampl_pct;         // Signed percent per channel.
  logic [21:0]   e1_mode;          // E1 mode per channel.
  logic [21:0]   arb_en;           // Arbitrary template per channel.
  int            failures;         // Mismatches seen.
  int            samples_checked;  // Comparisons made.

  tx_waveform_template_regs i_dut (
    .CLK_SYS_IN      (clk_sys),
    .SYS_RST_IN      (sys_rst),
    .PSEL_IN         (psel),
    .PENABLE_IN      (penable),
    .PWRITE_IN       (pwrite),
    .PADDR_IN        (paddr),
    .PWDATA_IN       (pwdata),
    .PRDATA_OUT      (prdata),
    .PREADY_OUT      (pready),
    .PSLVERR_OUT     (pslverr),
    .TX_AMPL_PCT_OUT (ampl_pct),
    .E1_MODE_OUT     (e1_mode),
    .ARB_WAVE_EN_OUT (arb_en)
  );

  // The clock toggles every half period.
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end

  // Prints the verdict and ends the run.
  task automatic test_done();
    if (failures == 0 && samples_checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // Byte address of a register offset within a channel block.
  function automatic logic [12:0] ba(input int ch, input logic [11:0] off);
    logic [11:0] base;
    base = (ch == 0) ? 12'h07C0 : 12'(12'h0040 * (ch - 1));
    return 13'({base + off, 2'b00});
  endfunction

  // One APB transfer; the request holds until pready is seen at a rising edge.
  task automatic apb(input logic wr, input logic [12:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clk_sys);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (pready === 1'b1) break;
    end
    if (n == 50) begin
      failures++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Register write that must be accepted.
  task automatic wr(input int ch, input logic [11:0] off, input logic [7:0] v);
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ba(ch, off), {24'h00_0000, v}, rd, err);
    `CHK(err, 1'b0)
  endtask

  // Register read compared with its expected byte.
  task automatic rd_chk(input int ch, input logic [11:0] off, input logic [7:0] e);
    logic [31:0] rd;
    logic        err;
    apb(1'b0, ba(ch, off), 32'h0000_0000, rd, err);
    `CHK(err, 1'b0)
    `CHK(rd, {24'h00_0000, e})
  endtask

  // Reset values in first, last and out-of-line channel, plus reserved bits.
  task automatic t_reset_values();
    rd_chk(1, 12'h007, 8'h36);
    rd_chk(0, 12'h007, 8'h36);
    rd_chk(21, 12'h008, 8'h00);
    rd_chk(21, 12'h009, 8'h00);
    `CHK(ampl_pct[9:0], 10'h000)
    wr(2, 12'h007, 8'hFF);
    rd_chk(2, 12'h007, 8'h3F);
    wr(2, 12'h009, 8'hFF);
    rd_chk(2, 12'h009, 8'h7F);
  endtask

  // Sets mode and factor, then checks the signed percent offset and mode flags.
  task automatic pct_chk(input int ch, input logic [7:0] sel, input logic [7:0] code,
                         input int e);
    wr(ch, 12'h006, sel);
    wr(ch, 12'h007, code);
    repeat (2) @(posedge clk_sys);
    `CHK(ampl_pct[ch*10 +: 10], 10'(e))
    `CHK(e1_mode[ch], (sel[3:1] == 3'b000))
    `CHK(arb_en[ch], sel[3])
  endtask

  // Step sizes and the extreme codes of both modes; only the T1/J1 low end clamps.
  task automatic t_scaling();
    pct_chk(3, 8'h02, 8'h37, 2);
    pct_chk(3, 8'h02, 8'h3F, 18);
    pct_chk(3, 8'h07, 8'h00, -100);
    pct_chk(0, 8'h00, 8'h21, 0);
    pct_chk(0, 8'h01, 8'h22, 3);
    pct_chk(0, 8'h00, 8'h3F, 90);
    pct_chk(0, 8'h00, 8'h00, -99);
    pct_chk(21, 8'h0F, 8'h36, 0);
  endtask

  // Stores samples, reads them back, including a saturated index code.
  task automatic t_ram_access();
    wr(21, 12'h006, 8'h08);
    wr(21, 12'h009, 8'h55);
    wr(21, 12'h008, 8'h45);
    wr(21, 12'h008, 8'h05);
    wr(21, 12'h009, 8'h00);
    wr(21, 12'h008, 8'h65);
    rd_chk(21, 12'h009, 8'h55);
    rd_chk(21, 12'h008, 8'h65);
    wr(21, 12'h008, 8'h13);
    wr(21, 12'h009, 8'h2A);
    wr(21, 12'h008, 8'h53);
    wr(21, 12'h008, 8'h00);
    wr(21, 12'h009, 8'h00);
    wr(21, 12'h008, 8'h7F);
    rd_chk(21, 12'h009, 8'h2A);
  endtask

  // Reads that must not load: preset template selected, then access disabled.
  task automatic t_gating();
    wr(21, 12'h006, 8'h02);
    wr(21, 12'h008, 8'h65);
    repeat (3) @(posedge clk_sys);
    rd_chk(21, 12'h009, 8'h2A);
    wr(21, 12'h006, 8'h08);
    wr(21, 12'h008, 8'h25);
    repeat (3) @(posedge clk_sys);
    rd_chk(21, 12'h009, 8'h2A);
  endtask

  // Unmapped and misaligned addresses are refused; an unmapped read returns zero.
  task automatic t_unmapped();
    logic [31:0] rd;
    logic        err;
    apb(1'b1, ba(1, 12'h00A), 32'h0000_00FF, rd, err);
    `CHK(err, 1'b1)
    apb(1'b0, ba(1, 12'h00A), 32'h0000_0000, rd, err);
    `CHK(err, 1'b1)
    `CHK(rd, 32'h0000_0000)
    apb(1'b1, 13'h001D, 32'h0000_0011, rd, err);
    `CHK(err, 1'b1)
    apb(1'b0, ba(22, 12'h007), 32'h0000_0000, rd, err);
    `CHK(err, 1'b1)
    rd_chk(1, 12'h007, 8'h36);
  endtask

  // Main sequence: reset, then every scenario in turn.
  initial begin
    failures        = 0;
    samples_checked = 0;
    sys_rst = 1'b1;
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 13'h0000;
    pwdata  = 32'h0000_0000;
    repeat (12) @(posedge clk_sys);
    sys_rst <= 1'b0;
    t_reset_values();
    t_scaling();
    t_ram_access();
    t_gating();
    t_unmapped();
    test_done();
  end
endmodule // tx_waveform_template_regs_tb

`default_nettype wire
